// file: verilog/hcrb_top.sv
// Host configuration register banks with EEPROM loader
`timescale 1ns/100ps
// Notes on behaviour
// - Strap high: load MAC from EEPROM word one
// - EEPROM words 1..3 fill low, mid, high
// - MAC writes never touch the EEPROM
// - Stored MAC is our destination address
// - Bytes first-first, bits LSB first on wire
// - Two-bit field selects on-chip bus speed
// - Config bit one presets speed 00 or 11
// - Strap high: fetch config word 6 after the MAC words
// - Enable bit 4 hands pins to software
// - Bit 3 reads EEPROM serial input pin
// - Bits 2-0 drive data, clock, select
// - TX self-test done bit 12, fail 11
// - RX self-test done bit 4, fail 3
// - Soft reset bit resets core, not host bus
// - Bus width bit loaded from config bit 0
// - Pause enable needs switch bit too
// - Pad enable pads frames under 64 bytes
// - CRC enable appends checksum to frames
// - TX enable runs; clear stops after frame
// - Status shows last transmitted frame ID
// - Banks 1, 4-15 reserved except bank select
// - Bank select at 0xE in every bank
module hcrb_top (
  // Clock and reset
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_sys_rst,
  // Host register port
  input  wire hcrb_pkg::hcrb_req_type i_bus_req,
  output logic [15:0]                o_bus_rdata,
  output logic                       o_bus_rvalid,
  // EEPROM pins and strap
  input  wire logic                  i_eeprom_present_strap,
  input  wire logic                  i_eeprom_serial_in_pin,
  output logic                       o_eeprom_serial_out_pin,
  output logic                       o_eeprom_serial_clock_pin,
  output logic                       o_eeprom_chip_select_pin,
  // Core status in
  input  wire hcrb_pkg::hcrb_bist_type i_bist,
  input  wire logic                  i_switch_global_ctrl_three,
  input  wire logic                  i_tx_busy,
  input  wire logic                  i_tx_frame_done,
  input  wire logic [5:0]            i_tx_frame_id,
  input  wire logic                  i_rx_da_valid,
  input  wire logic [47:0]           i_rx_da,
  // Core control out
  output logic [1:0]                 o_internal_bus_speed_sel,
  output logic                       o_core_soft_reset,
  output logic                       o_tx_module_run,
  output logic                       o_tx_pause_generate_enable,
  output logic                       o_tx_short_frame_pad_enable,
  output logic                       o_tx_append_fcs_enable,
  output logic                       o_bus_width_16,
  output logic                       o_da_match,
  output logic                       o_load_busy
);
  import hcrb_pkg::*;

  hcrb_state_type s_r;
  hcrb_state_type s_nxt;

  // ==========================================================
  // Helpers
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] wd,
                                        input logic [1:0]  be);
    merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  // Wire order: first byte (mac_lo[7:0]) in [47:40], last byte in [7:0]
  function automatic logic [47:0] wire_addr(input hcrb_state_type s);
    wire_addr = {s.mac_lo[7:0], s.mac_lo[15:8], s.mac_mid[7:0],
                 s.mac_mid[15:8], s.mac_hi[7:0], s.mac_hi[15:8]};
  endfunction

  function automatic logic ee_cmd_bit(input logic [1:0] idx,
                                      input logic [4:0] bitn);
    logic [8:0] cmd;
    logic [5:0] wa;
    wa  = (idx == 2'd3) ? EE_CFG_WORD : EE_MAC_WORD0 + 6'(idx);
    cmd = {EE_READ_CMD, wa};
    ee_cmd_bit = cmd[4'(5'd8 - bitn)];
  endfunction

  function automatic logic [15:0] rd_word(input hcrb_state_type s,
                                          input logic [3:0] a,
                                          input hcrb_bist_type b);
    rd_word = 16'h0000;
    if (a == OFS_BANKSEL) begin
      rd_word = {10'h000, s.bank};
    end else if (s.bank == BANK_MAC) begin
      if (a == OFS_W0) rd_word = s.mac_lo;
      else if (a == OFS_W1) rd_word = s.mac_mid;
      else if (a == OFS_W2) rd_word = s.mac_hi;
    end else if (s.bank == BANK_CFG) begin
      if (a == OFS_W0) begin
        rd_word = {14'h0000, s.speed};
      end else if (a == OFS_W1) begin
        rd_word[EE_EN_BIT] = s.ee_sw_en;
        rd_word[EE_IN_BIT] = s.di_f;
        rd_word[2:0] = s.ee_ctl;
      end else if (a == OFS_W2) begin
        rd_word[TXM_DONE_BIT] = b.tx_done;
        rd_word[TXM_FAIL_BIT] = b.tx_fail;
        rd_word[RXM_DONE_BIT] = b.rx_done;
        rd_word[RXM_FAIL_BIT] = b.rx_fail;
      end else if (a == OFS_W3) begin
        rd_word[0] = s.soft_rst;
      end else if (a == OFS_W4) begin
        rd_word[0] = s.bus_w16;
      end
    end else if (s.bank == BANK_TX) begin
      if (a == OFS_W0) rd_word = {12'h000, s.tx_ctl};
      else if (a == OFS_W1) rd_word = {10'h000, s.tx_fid};
    end
    // Other banks read zero
  endfunction

  // ==========================================================
  // Next state
  always_comb begin
    logic [15:0] w;
    logic        wr;
    s_nxt = s_r;
    w  = {s_r.ld_sh[14:0], s_r.di_f};
    wr = i_bus_req.cs & i_bus_req.wr;
    s_nxt.rvalid = 1'b0;
    s_nxt.di_s = {s_r.di_s[1:0], i_eeprom_serial_in_pin};
    if (s_r.di_s[1] == s_r.di_s[2]) s_nxt.di_f = s_r.di_s[2];
    s_nxt.strap_s = {s_r.strap_s[1:0], i_eeprom_present_strap};
    if (s_r.strap_s[1] == s_r.strap_s[2]) s_nxt.strap_f = s_r.strap_s[2];

    // Host writes; loader below wins on a collision
    if (wr) begin
      if (i_bus_req.addr == OFS_BANKSEL) begin
        s_nxt.bank = 6'(merge({10'h000, s_r.bank}, i_bus_req.wdata,
                              i_bus_req.be));
      end else if (s_r.bank == BANK_MAC) begin
        // Register only; EEPROM never written back
        if (i_bus_req.addr == OFS_W0)
          s_nxt.mac_lo = merge(s_r.mac_lo, i_bus_req.wdata, i_bus_req.be);
        else if (i_bus_req.addr == OFS_W1)
          s_nxt.mac_mid = merge(s_r.mac_mid, i_bus_req.wdata, i_bus_req.be);
        else if (i_bus_req.addr == OFS_W2)
          s_nxt.mac_hi = merge(s_r.mac_hi, i_bus_req.wdata, i_bus_req.be);
      end else if (s_r.bank == BANK_CFG && i_bus_req.be[0]) begin
        if (i_bus_req.addr == OFS_W0) begin
          s_nxt.speed = i_bus_req.wdata[1:0];
        end else if (i_bus_req.addr == OFS_W1) begin
          s_nxt.ee_sw_en = i_bus_req.wdata[EE_EN_BIT];
          s_nxt.ee_ctl = i_bus_req.wdata[2:0];
        end else if (i_bus_req.addr == OFS_W3) begin
          s_nxt.soft_rst = i_bus_req.wdata[0];
        end
      end else if (s_r.bank == BANK_TX && i_bus_req.be[0]) begin
        if (i_bus_req.addr == OFS_W0)
          s_nxt.tx_ctl = i_bus_req.wdata[3:0];
      end
      // Reserved locations ignore writes
    end
    if (i_bus_req.cs && i_bus_req.rd) begin
      s_nxt.rdata = rd_word(s_r, i_bus_req.addr, i_bist);
      s_nxt.rvalid = 1'b1;
    end

    // EEPROM loader after reset
    case (s_r.ld_st)
      LD_WAIT: begin
        s_nxt.ld_div = s_r.ld_div + 8'h01;
        if (s_r.ld_div == STRAP_WAIT) begin
          s_nxt.ld_div = 8'h00;
          if (s_r.strap_f) begin
            s_nxt.ld_st = LD_BIT;
            s_nxt.ld_busy = 1'b1;
          end else begin
            s_nxt.ld_st = LD_DONE;
          end
        end
      end
      LD_BIT: begin
        s_nxt.ld_div = s_r.ld_div + 8'h01;
        if (s_r.ld_div == EE_HALF_LAST) begin
          s_nxt.ld_div = 8'h00;
          s_nxt.ld_ph = ~s_r.ld_ph;
          if (s_r.ld_ph) begin
            s_nxt.ld_bit = s_r.ld_bit + 5'd1;
            if (s_r.ld_bit >= EE_CMD_BITS && s_r.ld_bit <= EE_LAST_BIT)
              s_nxt.ld_sh = w;
            if (s_r.ld_bit == EE_LAST_BIT) begin
              case (s_r.ld_idx)
                2'd0: s_nxt.mac_lo = w;
                2'd1: s_nxt.mac_mid = w;
                2'd2: s_nxt.mac_hi = w;
                default: begin
                  s_nxt.speed = w[1] ? SPEED_SLOW : SPEED_RST;
                  s_nxt.bus_w16 = w[0];
                end
              endcase
            end
            if (s_r.ld_bit == EE_GAP_BIT) begin
              s_nxt.ld_bit = 5'd0;
              s_nxt.ld_idx = s_r.ld_idx + 2'd1;
              if (s_r.ld_idx == 2'd3) begin
                s_nxt.ld_st = LD_DONE;
                s_nxt.ld_busy = 1'b0;
              end
            end
          end
        end
      end
      default: begin
        s_nxt.ld_st = LD_DONE;
      end
    endcase

    // Pin ownership: loader, then software, else idle
    if (s_nxt.ld_busy) begin
      s_nxt.ee_cs = s_nxt.ld_bit != EE_GAP_BIT;
      s_nxt.ee_sk = s_nxt.ld_ph && s_nxt.ld_bit != EE_GAP_BIT;
      s_nxt.ee_do = (s_nxt.ld_bit < EE_CMD_BITS) &&
                    ee_cmd_bit(s_nxt.ld_idx, s_nxt.ld_bit);
    end else if (s_nxt.ee_sw_en) begin
      s_nxt.ee_do = s_nxt.ee_ctl[2];
      s_nxt.ee_sk = s_nxt.ee_ctl[1];
      s_nxt.ee_cs = s_nxt.ee_ctl[0];
    end else begin
      s_nxt.ee_do = 1'b0;
      s_nxt.ee_sk = 1'b0;
      s_nxt.ee_cs = 1'b0;
    end

    // Transmit control
    if (i_tx_frame_done) s_nxt.tx_fid = i_tx_frame_id;
    if (s_nxt.soft_rst) begin
      s_nxt.tx_run = 1'b0;
    end else if (s_nxt.tx_ctl[TX_EN_BIT]) begin
      s_nxt.tx_run = 1'b1;
    end else if (!i_tx_busy) begin
      s_nxt.tx_run = 1'b0;
    end
    s_nxt.pause_en = s_nxt.tx_ctl[TX_PAUSE_BIT] &
                     i_switch_global_ctrl_three;
    s_nxt.da_match = i_rx_da_valid && (i_rx_da == wire_addr(s_r));
  end

  // ==========================================================
  // State register
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s_r <= '0;
      s_r.ld_st <= LD_WAIT;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign o_bus_rdata = s_r.rdata;
  assign o_bus_rvalid = s_r.rvalid;
  assign o_eeprom_serial_out_pin = s_r.ee_do;
  assign o_eeprom_serial_clock_pin = s_r.ee_sk;
  assign o_eeprom_chip_select_pin = s_r.ee_cs;
  assign o_internal_bus_speed_sel = s_r.speed;
  assign o_core_soft_reset = s_r.soft_rst;
  assign o_tx_module_run = s_r.tx_run;
  assign o_tx_pause_generate_enable = s_r.pause_en;
  assign o_tx_short_frame_pad_enable = s_r.tx_ctl[TX_PAD_BIT];
  assign o_tx_append_fcs_enable = s_r.tx_ctl[TX_FCS_BIT];
  assign o_bus_width_16 = s_r.bus_w16;
  assign o_da_match = s_r.da_match;
  assign o_load_busy = s_r.ld_busy;

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);

  // Strobes seen by the checks
  logic cfg_wr;
  logic ld_store;
  assign cfg_wr = i_bus_req.cs & i_bus_req.wr & i_bus_req.be[0] &
                  (s_r.bank == BANK_CFG);
  assign ld_store = s_r.ld_st == LD_BIT && s_r.ld_ph &&
                    s_r.ld_div == EE_HALF_LAST && s_r.ld_bit == EE_LAST_BIT;

  a_bank_sel_write: assert property (
    i_bus_req.cs && i_bus_req.wr && i_bus_req.addr == OFS_BANKSEL &&
    i_bus_req.be[0] |=> s_r.bank == $past(i_bus_req.wdata[5:0]))
    else $error("bank select not written");
  a_bank_sel_read: assert property (
    i_bus_req.cs && i_bus_req.rd && i_bus_req.addr == OFS_BANKSEL
    |=> o_bus_rvalid && o_bus_rdata == {10'h000, $past(s_r.bank)})
    else $error("bank select read wrong");
  a_reserved_bank: assert property (
    i_bus_req.cs && i_bus_req.rd && i_bus_req.addr != OFS_BANKSEL &&
    (s_r.bank == 6'h01 || (s_r.bank >= 6'h04 && s_r.bank <= 6'h0f))
    |=> o_bus_rdata == 16'h0000)
    else $error("reserved bank read nonzero");
  a_fid_capture: assert property (
    i_tx_frame_done |=> s_r.tx_fid == $past(i_tx_frame_id))
    else $error("frame id not captured");
  a_tx_stop_wait: assert property (
    o_tx_module_run && i_tx_busy && !o_core_soft_reset
    |=> o_tx_module_run || o_core_soft_reset)
    else $error("transmit stopped mid frame");
  a_soft_rst_hold: assert property (
    o_core_soft_reset |-> !o_tx_module_run)
    else $error("transmit runs in soft reset");
  a_pin_sw_ctl: assert property (
    !s_r.ld_busy && s_r.ee_sw_en |-> {o_eeprom_serial_out_pin,
    o_eeprom_serial_clock_pin, o_eeprom_chip_select_pin} == s_r.ee_ctl)
    else $error("eeprom pins not following bits");
  a_pin_idle: assert property (
    !s_r.ld_busy && !s_r.ee_sw_en |-> !o_eeprom_chip_select_pin &&
    !o_eeprom_serial_clock_pin)
    else $error("eeprom pins driven without access");
  a_pause_gate: assert property (
    !i_switch_global_ctrl_three |=> !o_tx_pause_generate_enable)
    else $error("pause enabled without switch bit");
  a_da_match: assert property (
    i_rx_da_valid && i_rx_da != wire_addr(s_r) |=> !o_da_match)
    else $error("false destination match");
  a_speed_write: assert property (
    cfg_wr && i_bus_req.addr == OFS_W0 && !s_r.ld_busy
    |=> o_internal_bus_speed_sel == $past(i_bus_req.wdata[1:0]))
    else $error("bus speed not written");
  a_speed_preset: assert property (
    ld_store && s_r.ld_idx == 2'd3
    |=> o_internal_bus_speed_sel == {2{$past(s_r.ld_sh[0])}})
    else $error("bus speed not preset from config");
  a_width_load: assert property (
    ld_store && s_r.ld_idx == 2'd3 |=> o_bus_width_16 == $past(s_r.di_f))
    else $error("bus width not loaded");
  a_mac_load: assert property (
    ld_store && s_r.ld_idx == 2'd0
    |=> s_r.mac_lo == $past({s_r.ld_sh[14:0], s_r.di_f}))
    else $error("low address word not loaded");
  a_load_addr: assert property (
    s_r.ld_busy && s_r.ld_idx == 2'd0 && s_r.ld_bit == 5'd8
    |-> o_eeprom_serial_out_pin == EE_MAC_WORD0[0])
    else $error("first load word not one");
  a_ee_in_read: assert property (
    i_bus_req.cs && i_bus_req.rd && s_r.bank == BANK_CFG &&
    i_bus_req.addr == OFS_W1 |=> o_bus_rdata[EE_IN_BIT] == $past(s_r.di_f))
    else $error("serial input bit not read");
  a_bist_read: assert property (
    i_bus_req.cs && i_bus_req.rd && s_r.bank == BANK_CFG &&
    i_bus_req.addr == OFS_W2 |=>
    o_bus_rdata[TXM_DONE_BIT:TXM_FAIL_BIT] == $past(i_bist[3:2]) &&
    o_bus_rdata[RXM_DONE_BIT:RXM_FAIL_BIT] == $past(i_bist[1:0]))
    else $error("self-test flags read wrong");
  a_tx_bits: assert property (
    i_bus_req.cs && i_bus_req.wr && i_bus_req.be[0] && s_r.bank == BANK_TX &&
    i_bus_req.addr == OFS_W0 |=>
    o_tx_short_frame_pad_enable == $past(i_bus_req.wdata[TX_PAD_BIT]) &&
    o_tx_append_fcs_enable == $past(i_bus_req.wdata[TX_FCS_BIT]))
    else $error("pad or checksum enable not written");
  a_soft_rst_write: assert property (
    cfg_wr && i_bus_req.addr == OFS_W3
    |=> o_core_soft_reset == $past(i_bus_req.wdata[0]))
    else $error("soft reset not written");
  a_soft_rst_keep: assert property (
    o_core_soft_reset && !(cfg_wr && i_bus_req.addr == OFS_W3)
    |=> o_core_soft_reset)
    else $error("soft reset released on its own");

  c_load_done: cover property (s_r.ld_busy ##1 !s_r.ld_busy);
  c_sw_access: cover property (s_r.ee_sw_en && o_eeprom_serial_clock_pin);
  c_tx_drain: cover property (o_tx_module_run && !s_r.tx_ctl[0] ##1
                              !o_tx_module_run);
  c_match: cover property (o_da_match);
  c_soft_rst: cover property (o_core_soft_reset ##1 !o_core_soft_reset);

endmodule

// file: verilog/hcrb_pkg.sv
// Constants, types and state layout of the host configuration banks
package hcrb_pkg;

  // ==========================================================
  // Bank numbers and I/O offsets
  localparam logic [5:0] BANK_MAC    = 6'h02;
  localparam logic [5:0] BANK_CFG    = 6'h03;
  localparam logic [5:0] BANK_TX     = 6'h10;
  localparam logic [3:0] OFS_BANKSEL = 4'he;
  localparam logic [3:0] OFS_W0      = 4'h0;
  localparam logic [3:0] OFS_W1      = 4'h2;
  localparam logic [3:0] OFS_W2      = 4'h4;
  localparam logic [3:0] OFS_W3      = 4'h6;
  localparam logic [3:0] OFS_W4      = 4'h8;

  // ==========================================================
  // Field positions
  localparam int EE_EN_BIT    = 4;
  localparam int EE_IN_BIT    = 3;
  localparam int TXM_DONE_BIT = 12;
  localparam int TXM_FAIL_BIT = 11;
  localparam int RXM_DONE_BIT = 4;
  localparam int RXM_FAIL_BIT = 3;
  localparam int TX_PAUSE_BIT = 3;
  localparam int TX_PAD_BIT   = 2;
  localparam int TX_FCS_BIT   = 1;
  localparam int TX_EN_BIT    = 0;

  // ==========================================================
  // Reset and preset values
  localparam logic [5:0]  BANK_RST  = 6'h00;
  localparam logic [15:0] MAC_RST   = 16'h0000;
  localparam logic [1:0]  SPEED_RST = 2'h0;
  localparam logic [1:0]  SPEED_SLOW = 2'h3;

  // ==========================================================
  // EEPROM load sequence
  localparam logic [5:0] EE_MAC_WORD0 = 6'h01;
  localparam logic [5:0] EE_CFG_WORD  = 6'h06;
  localparam logic [2:0] EE_READ_CMD  = 3'h6;
  localparam logic [4:0] EE_CMD_BITS  = 5'd9;
  localparam logic [4:0] EE_LAST_BIT  = 5'd24;
  localparam logic [4:0] EE_GAP_BIT   = 5'd25;
  localparam int EE_HALF_NS  = 500;
  localparam int SYS_CLK_NS  = 10;
  localparam int EE_HALF_CYC = EE_HALF_NS / SYS_CLK_NS;
  localparam logic [7:0] EE_HALF_LAST = 8'(EE_HALF_CYC - 1);
  localparam logic [7:0] STRAP_WAIT   = 8'h08;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {LD_WAIT, LD_BIT, LD_DONE} hcrb_ld_type;

  typedef struct packed {
    logic        cs;
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [1:0]  be;
    logic [15:0] wdata;
  } hcrb_req_type;

  typedef struct packed {
    logic tx_done;
    logic tx_fail;
    logic rx_done;
    logic rx_fail;
  } hcrb_bist_type;

  typedef struct packed {
    logic [5:0]  bank;
    logic [15:0] mac_lo;
    logic [15:0] mac_mid;
    logic [15:0] mac_hi;
    logic [1:0]  speed;
    logic        ee_sw_en;
    logic [2:0]  ee_ctl;
    logic        soft_rst;
    logic        bus_w16;
    logic [3:0]  tx_ctl;
    logic        tx_run;
    logic        pause_en;
    logic [5:0]  tx_fid;
    logic [15:0] rdata;
    logic        rvalid;
    logic        ee_cs;
    logic        ee_sk;
    logic        ee_do;
    logic        da_match;
    logic [2:0]  di_s;
    logic        di_f;
    logic [2:0]  strap_s;
    logic        strap_f;
    hcrb_ld_type ld_st;
    logic [1:0]  ld_idx;
    logic [4:0]  ld_bit;
    logic        ld_ph;
    logic [7:0]  ld_div;
    logic [15:0] ld_sh;
    logic        ld_busy;
  } hcrb_state_type;

endpackage

// file: testbench/hcrb_eeprom_model.sv
// Serial EEPROM model answering word reads
`timescale 1ns/100ps
module hcrb_eeprom_model (
  // EEPROM pins
  input  wire logic i_cs,
  input  wire logic i_sk,
  input  wire logic i_di,
  output logic      o_do
);
  logic [15:0] mem [64];
  logic [8:0]  cmd = 9'h000;
  int          slot = 0;

  initial o_do = 1'b0;

  // ==========================================================
  // Command in, then data out MSB first
  always @(posedge i_sk) begin
    if (i_cs) begin
      if (slot < 9)
        cmd = {cmd[7:0], i_di};
      else if (slot < 25 && cmd[8:6] == 3'b110)
        o_do <= mem[cmd[5:0]][24 - slot];
      slot++;
    end
  end

  // Released line shows the inverse of the last bit
  always @(negedge i_cs) begin
    slot = 0;
    o_do <= ~o_do;
  end
endmodule

// file: testbench/host_config_register_banks_tb.sv
// Self-checking bench for the host configuration register banks
`timescale 1ns/100ps
module host_config_register_banks_tb;
  import hcrb_pkg::*;
  // ==========================================================
  // Design signals
  hcrb_req_type  i_bus_req = '0;
  hcrb_bist_type i_bist = '0;
  logic          i_sys_clk = 1'b0;
  logic          i_sys_rst = 1'b1;
  logic          i_eeprom_present_strap = 1'b1;
  logic          i_switch_global_ctrl_three = 1'b0;
  logic          i_tx_busy = 1'b0;
  logic          i_tx_frame_done = 1'b0;
  logic          i_rx_da_valid = 1'b0;
  logic [5:0]    i_tx_frame_id = 6'h00;
  logic [47:0]   i_rx_da = 48'h0;
  logic          i_eeprom_serial_in_pin;
  logic [15:0]   o_bus_rdata;
  logic [1:0]    o_internal_bus_speed_sel;
  logic          o_bus_rvalid, o_da_match, o_load_busy, o_bus_width_16;
  logic          o_eeprom_serial_out_pin, o_eeprom_serial_clock_pin;
  logic          o_eeprom_chip_select_pin, o_core_soft_reset;
  logic          o_tx_module_run, o_tx_pause_generate_enable;
  logic          o_tx_short_frame_pad_enable, o_tx_append_fcs_enable;
  // ==========================================================
  // Reference model state
  logic [15:0]   e_mac [3];
  logic [15:0]   r, d;
  logic [5:0]    bank, e_fid;
  logic [5:0]    rsv [4] = '{6'h01, 6'h04, 6'h0f, 6'h3f};
  logic [4:0]    e_ee;
  logic [3:0]    e_txc;
  logic [1:0]    e_spd;
  logic          e_w16, e_rst;
  int            n_errors = 0, comparisons = 0, cyc = 0;
  wire  [2:0]    pins = {o_eeprom_serial_out_pin, o_eeprom_serial_clock_pin,
                         o_eeprom_chip_select_pin};
  wire  [3:0]    txo = {o_tx_pause_generate_enable,
                        o_tx_short_frame_pad_enable,
                        o_tx_append_fcs_enable, o_tx_module_run};

  always #5 i_sys_clk = ~i_sys_clk;

  hcrb_top dut_u (
    .i_sys_clk, .i_sys_rst, .i_bus_req, .o_bus_rdata, .o_bus_rvalid,
    .i_eeprom_present_strap, .i_eeprom_serial_in_pin,
    .o_eeprom_serial_out_pin, .o_eeprom_serial_clock_pin,
    .o_eeprom_chip_select_pin, .i_bist, .i_switch_global_ctrl_three,
    .i_tx_busy, .i_tx_frame_done, .i_tx_frame_id, .i_rx_da_valid,
    .i_rx_da, .o_internal_bus_speed_sel, .o_core_soft_reset,
    .o_tx_module_run, .o_tx_pause_generate_enable,
    .o_tx_short_frame_pad_enable, .o_tx_append_fcs_enable,
    .o_bus_width_16, .o_da_match, .o_load_busy
  );

  hcrb_eeprom_model ee_u (
    .i_cs (o_eeprom_chip_select_pin),
    .i_sk (o_eeprom_serial_clock_pin),
    .i_di (o_eeprom_serial_out_pin),
    .o_do (i_eeprom_serial_in_pin)
  );

  // ==========================================================
  // Helpers
  task automatic print_verdict();
    if (n_errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      print_verdict();
    end
  end

  task automatic chk(logic [15:0] got, logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tick(int n);
    repeat (n) @(negedge i_sys_clk);
  endtask

  task automatic wr(logic [3:0] a, logic [15:0] v, logic [1:0] be = 2'b11);
    @(negedge i_sys_clk);
    i_bus_req = '{1'b1, 1'b1, 1'b0, a, be, v};
    @(negedge i_sys_clk);
    i_bus_req = '0;
  endtask

  task automatic rd(logic [3:0] a);
    int k;
    @(negedge i_sys_clk);
    i_bus_req = '{1'b1, 1'b0, 1'b1, a, 2'b11, 16'h0000};
    @(negedge i_sys_clk);
    i_bus_req = '0;
    for (k = 0; k < 3 && o_bus_rvalid !== 1'b1; k++) @(negedge i_sys_clk);
    chk({15'h0, o_bus_rvalid}, 16'h0001);
    r = o_bus_rdata;
  endtask

  // Register view of the reference model
  function automatic logic [15:0] exp_rd(logic [3:0] a);
    logic [15:0] v;
    case ({bank, a})
      {BANK_MAC, OFS_W0}: v = e_mac[0];
      {BANK_MAC, OFS_W1}: v = e_mac[1];
      {BANK_MAC, OFS_W2}: v = e_mac[2];
      {BANK_CFG, OFS_W0}: v = {14'h0, e_spd};
      {BANK_CFG, OFS_W1}: v = {11'h0, e_ee[4], i_eeprom_serial_in_pin,
                               e_ee[2:0]};
      {BANK_CFG, OFS_W2}: v = {3'h0, i_bist[3:2], 6'h0, i_bist[1:0],
                               3'h0};
      {BANK_CFG, OFS_W3}: v = {15'h0, e_rst};
      {BANK_CFG, OFS_W4}: v = {15'h0, e_w16};
      {BANK_TX, OFS_W0}: v = {12'h0, e_txc};
      {BANK_TX, OFS_W1}: v = {10'h0, e_fid};
      default: v = (a == OFS_BANKSEL) ? {10'h0, bank} : 16'h0;
    endcase
    return v;
  endfunction

  task automatic rc(logic [3:0] a);
    rd(a);
    chk(r, exp_rd(a));
  endtask

  task automatic rmac();
    for (int k = 0; k < 6; k += 2) rc(4'(k));
  endtask

  task automatic setb(logic [5:0] b);
    wr(OFS_BANKSEL, {10'h000, b});
    bank = b;
  endtask

  // One bit-banged clock period with select held
  task automatic eb(logic b);
    wr(OFS_W1, {11'h0, 1'b1, 1'b0, b, 2'b01});
    wr(OFS_W1, {11'h0, 1'b1, 1'b0, b, 2'b11});
    tick(1);
    chk({13'h0, pins}, {13'h0, b, 2'b11});
  endtask

  // Address as it arrives on the wire, first byte in [47:40], last byte in [7:0]
  function automatic logic [47:0] wire_da();
    return {e_mac[0][7:0], e_mac[0][15:8], e_mac[1][7:0],
            e_mac[1][15:8], e_mac[2][7:0], e_mac[2][15:8]};
  endfunction

  task automatic da(logic [47:0] v, logic m);
    logic seen;
    seen = 1'b0;
    @(negedge i_sys_clk);
    i_rx_da = v;
    i_rx_da_valid = 1'b1;
    @(negedge i_sys_clk);
    i_rx_da_valid = 1'b0;
    repeat (2) begin
      seen |= o_da_match;
      @(negedge i_sys_clk);
    end
    chk({15'h0, seen}, {15'h0, m});
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    int k;
    logic [5:0] a;
    logic [8:0] cmd;
    void'($urandom(88468));
    for (k = 0; k < 64; k++) ee_u.mem[k] = 16'($urandom);
    ee_u.mem[6][1:0] = 2'b11;
    e_mac = '{ee_u.mem[1], ee_u.mem[2], ee_u.mem[3]};
    {e_spd, e_w16} = 3'b111;
    {e_ee, e_txc, e_fid, e_rst, bank} = '0;
    tick(20);
    i_sys_rst = 1'b0;
    for (k = 0; k < 100 && o_load_busy !== 1'b1; k++) tick(1);
    chk({15'h0, o_load_busy}, 16'h0001);
    for (k = 0; k < 20000 && o_load_busy !== 1'b0; k++) tick(1);
    setb(BANK_MAC);
    rmac();
    setb(BANK_CFG);
    rc(OFS_W0);
    rc(OFS_W4);
    chk({13'h0, o_bus_width_16, o_internal_bus_speed_sel}, 16'h7);
    for (k = 0; k < 4; k++) begin
      wr(OFS_W0, 16'(k));
      e_spd = 2'(k);
      rc(OFS_W0);
      chk({14'h0, o_internal_bus_speed_sel}, 16'(k));
    end
    for (k = 0; k < 6; k++) begin
      i_bist = 4'($urandom);
      rc(OFS_W2);
    end
    wr(OFS_W1, 16'h000f);
    e_ee = 5'h07;
    rc(OFS_W1);
    chk({13'h0, pins}, 16'h0);
    a = 6'($urandom);
    cmd = {EE_READ_CMD, a};
    for (k = 8; k >= 0; k--) eb(cmd[k]);
    for (k = 15; k >= 0; k--) begin
      eb(1'b0);
      tick(3);
      rd(OFS_W1);
      chk({15'h0, r[3]}, {15'h0, ee_u.mem[a][k]});
    end
    wr(OFS_W1, 16'h0010);
    wr(OFS_W1, 16'h0000);
    e_ee = 5'h00;
    setb(BANK_MAC);
    d = 16'($urandom);
    wr(OFS_W0, d, 2'b01);
    wr(OFS_W1, d, 2'b10);
    wr(OFS_W2, d);
    e_mac[0][7:0] = d[7:0];
    e_mac[1][15:8] = d[15:8];
    e_mac[2] = d;
    rmac();
    chk({15'h0, o_eeprom_chip_select_pin}, 16'h0);
    da(wire_da(), 1'b1);
    da({<<8{wire_da()}}, 1'b0);
    da(wire_da() ^ 48'h1, 1'b0);
    da(wire_da() ^ (48'h1 << 47), 1'b0);
    setb(BANK_TX);
    for (k = 0; k < 16; k++) begin
      i_switch_global_ctrl_three = 1'($urandom);
      wr(OFS_W0, 16'(k));
      e_txc = 4'(k);
      rc(OFS_W0);
      chk({12'h0, txo}, {12'h0, e_txc[3] & i_switch_global_ctrl_three,
                         e_txc[2:0]});
    end
    i_tx_busy = 1'b1;
    wr(OFS_W0, 16'h0001);
    wr(OFS_W0, 16'h0000);
    tick(3);
    chk({15'h0, o_tx_module_run}, 16'h1);
    i_tx_busy = 1'b0;
    tick(3);
    chk({15'h0, o_tx_module_run}, 16'h0);
    d = 16'($urandom);
    i_tx_frame_done = 1'b1;
    i_tx_frame_id = d[5:0];
    tick(1);
    i_tx_frame_id = d[11:6];
    tick(1);
    i_tx_frame_done = 1'b0;
    e_fid = d[11:6];
    rc(OFS_W1);
    wr(OFS_W0, 16'h0001);
    e_txc = 4'h1;
    setb(BANK_CFG);
    wr(OFS_W3, 16'h0001);
    e_rst = 1'b1;
    tick(30);
    chk({14'h0, o_core_soft_reset, o_tx_module_run}, 16'h2);
    rc(OFS_W3);
    setb(BANK_MAC);
    rmac();
    setb(BANK_CFG);
    wr(OFS_W3, 16'h0000);
    e_rst = 1'b0;
    tick(2);
    chk({15'h0, o_core_soft_reset}, 16'h0);
    foreach (rsv[i]) begin
      setb(rsv[i]);
      wr(OFS_W2, 16'hffff);
      for (k = 0; k < 16; k += 2) rc(4'(k));
    end
    i_sys_rst = 1'b1;
    i_eeprom_present_strap = 1'b0;
    tick(20);
    i_sys_rst = 1'b0;
    e_mac = '{default: 16'h0};
    {e_spd, e_w16, e_ee, e_txc, e_fid, bank} = '0;
    tick(40);
    chk({15'h0, o_load_busy}, 16'h0);
    chk({14'h0, o_internal_bus_speed_sel}, 16'h0);
    setb(BANK_MAC);
    rmac();
    print_verdict();
  end
endmodule
